//--- core/pot23_terminal_connect_ctrl.sv
// Overview of operation
// - A zero shutdown-force bit (bit 7 net 3, bit 3 net 2) puts that network into legacy shutdown.
// - A one shutdown-force bit leaves the terminals under the network's own connect bits.
// - The wiper connect bit (bit 5 net 3, bit 1 net 2) connects the wiper when one, isolates when zero.
// - The terminal A bit (bit 6 net 3, bit 2 net 2) connects terminal A when one, isolates when zero.
// - Power-on or brown-out reset loads all nine bits with ones.
// - While a network's lock is set, writes to its four bits are ignored.
// - In shutdown terminal A is isolated and the wiper is tied to terminal B, connect bits ignored.
// - Shutdown never alters stored bits; on exit the stored bits control the terminals again.
`timescale 1ns/1ps
`include "pot23_defs.svh"
module pot23_terminal_connect_ctrl
    import pot23_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic writeStrobe,
    input wire logic [8:0] writeData,
    input wire logic net2Lock,
    input wire logic net3Lock,
    output logic [8:0] readData,
    output logic net2TermAConnect,
    output logic net2WiperConnect,
    output logic net2TermBConnect,
    output logic net2WiperToB,
    output logic net3TermAConnect,
    output logic net3WiperConnect,
    output logic net3TermBConnect,
    output logic net3WiperToB
);
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [8:0] readData_next;
    pot23_mode_e net3Mode;
    pot23_mode_e net2Mode;
    logic net3TermAConnect_next;
    logic net3WiperConnect_next;
    logic net3TermBConnect_next;
    logic net3WiperToB_next;
    logic net2TermAConnect_next;
    logic net2WiperConnect_next;
    logic net2TermBConnect_next;
    logic net2WiperToB_next;
    wire logic write2 = writeStrobe && !net2Lock;
    wire logic write3 = writeStrobe && !net3Lock;

    // only the write path touches ctrl_reg, so shutdown cannot corrupt it
    assign ctrl_next[7:4] = write3 ? writeData[7:4] : ctrl_reg[7:4];
    assign ctrl_next[3:0] = write2 ? writeData[3:0] : ctrl_reg[3:0];

    // decoded from ctrl_next so the pins move on the same edge as readData
    assign net3Mode = ctrl_next[`POT23_N3_FORCE_N_BIT] ? POT23_NORMAL : POT23_SHUTDOWN;
    assign net2Mode = ctrl_next[`POT23_N2_FORCE_N_BIT] ? POT23_NORMAL : POT23_SHUTDOWN;
    wire logic down3 = (net3Mode == POT23_SHUTDOWN);
    wire logic down2 = (net2Mode == POT23_SHUTDOWN);

    assign readData_next = {1'b1, ctrl_next};
    // shutdown: A off, W tied to B, individual bits ignored
    assign net3TermAConnect_next = !down3 && ctrl_next[`POT23_N3_A_BIT];
    assign net3WiperConnect_next = down3 || ctrl_next[`POT23_N3_W_BIT];
    assign net3TermBConnect_next = down3 || ctrl_next[`POT23_N3_B_BIT];
    assign net3WiperToB_next = down3;
    assign net2TermAConnect_next = !down2 && ctrl_next[`POT23_N2_A_BIT];
    assign net2WiperConnect_next = down2 || ctrl_next[`POT23_N2_W_BIT];
    assign net2TermBConnect_next = down2 || ctrl_next[`POT23_N2_B_BIT];
    assign net2WiperToB_next = down2;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= 8'(`POT23_RESET_VAL);
            readData <= `POT23_RESET_VAL;
            net2TermAConnect <= 1'b1;
            net2WiperConnect <= 1'b1;
            net2TermBConnect <= 1'b1;
            net2WiperToB <= 1'b0;
            net3TermAConnect <= 1'b1;
            net3WiperConnect <= 1'b1;
            net3TermBConnect <= 1'b1;
            net3WiperToB <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            readData <= readData_next;
            net3TermAConnect <= net3TermAConnect_next;
            net3WiperConnect <= net3WiperConnect_next;
            net3TermBConnect <= net3TermBConnect_next;
            net3WiperToB <= net3WiperToB_next;
            net2TermAConnect <= net2TermAConnect_next;
            net2WiperConnect <= net2WiperConnect_next;
            net2TermBConnect <= net2TermBConnect_next;
            net2WiperToB <= net2WiperToB_next;
        end
    end

    // write acceptance, hold windows and shutdown exits shared by the properties below
    sequence net3Write_s;
        writeStrobe && !net3Lock;
    endsequence
    sequence net3Held_s;
        !writeStrobe || net3Lock;
    endsequence
    sequence net2Held_s;
        !writeStrobe || net2Lock;
    endsequence
    sequence down3Exit_s;
        !readData[7] ##1 readData[7];
    endsequence
    sequence down2Exit_s;
        !readData[3] ##1 readData[3];
    endsequence

    top_bit_a: assert property (
        @(posedge clk) disable iff (reset)
        readData[8] == 1'b1)
        else $error("reserved bit read as zero");

    wr_top_a: assert property (
        @(posedge clk) disable iff (reset)
        (writeStrobe && !writeData[8]) |=> readData[8])
        else $error("reserved bit followed a written zero");

    shut3_a: assert property (
        @(posedge clk) disable iff (reset)
        !readData[7] |-> (!net3TermAConnect && net3WiperToB))
        else $error("net3 not in shutdown");

    force2_a: assert property (
        @(posedge clk) disable iff (reset)
        !readData[3] |-> (!net2TermAConnect && net2WiperToB))
        else $error("net2 not forced into shutdown");

    shut2_a: assert property (
        @(posedge clk) disable iff (reset)
        !readData[3] |-> (!net2TermAConnect && net2WiperToB && net2TermBConnect))
        else $error("net2 not in shutdown");

    short3_a: assert property (
        @(posedge clk) disable iff (reset)
        !readData[7] |-> (net3WiperConnect && net3TermBConnect && !net3TermAConnect))
        else $error("net3 wiper not tied to terminal B");

    run3_a: assert property (
        @(posedge clk) disable iff (reset)
        readData[7] |-> (net3TermAConnect == readData[6] && net3WiperConnect == readData[5]
        && net3TermBConnect == readData[4] && !net3WiperToB))
        else $error("net3 terminals differ from bits");

    free2_a: assert property (
        @(posedge clk) disable iff (reset)
        readData[3] |-> !net2WiperToB)
        else $error("net2 shorted while not forced");

    run2_a: assert property (
        @(posedge clk) disable iff (reset)
        readData[3] |-> (net2TermAConnect == readData[2] && net2WiperConnect == readData[1]
        && net2TermBConnect == readData[0]))
        else $error("net2 terminals differ from bits");

    wiper3_a: assert property (
        @(posedge clk) disable iff (reset)
        readData[7] |-> (net3WiperConnect == readData[5]))
        else $error("net3 wiper differs from its bit");

    pin_a_a: assert property (
        @(posedge clk) disable iff (reset)
        net2TermAConnect |-> readData[2] && readData[3])
        else $error("net2 terminal A connected wrongly");

    term_a3_a: assert property (
        @(posedge clk) disable iff (reset)
        net3TermAConnect |-> readData[7] && readData[6])
        else $error("net3 terminal A connected wrongly");

    pin_b_a: assert property (
        @(posedge clk) disable iff (reset)
        !net3TermBConnect |-> readData[7] && !readData[4])
        else $error("net3 terminal B isolated wrongly");

    term_b2_a: assert property (
        @(posedge clk) disable iff (reset)
        !net2TermBConnect |-> readData[3] && !readData[0])
        else $error("net2 terminal B isolated wrongly");

    reset_val_a: assert property (
        @(posedge clk)
        $fell(reset) |-> readData == `POT23_RESET_VAL)
        else $error("reset value wrong");

    reset_pins_a: assert property (
        @(posedge clk)
        $fell(reset) |-> (net2TermAConnect && net2WiperConnect && net2TermBConnect && !net2WiperToB
        && net3TermAConnect && net3WiperConnect && net3TermBConnect && !net3WiperToB))
        else $error("terminals not all connected after reset");

    lock3_a: assert property (
        @(posedge clk) disable iff (reset)
        net3Lock |=> $stable(readData[7:4]))
        else $error("locked net3 bits changed");

    lock2_a: assert property (
        @(posedge clk) disable iff (reset)
        net2Lock |=> $stable(readData[3:0]))
        else $error("locked net2 bits changed");

    wr_store3_a: assert property (
        @(posedge clk) disable iff (reset)
        net3Write_s |=> readData[7:4] == $past(writeData[7:4]))
        else $error("write to net3 bits lost");

    wr_store_a: assert property (
        @(posedge clk) disable iff (reset)
        (writeStrobe && !net2Lock) |=> readData[3:0] == $past(writeData[3:0]))
        else $error("write to net2 bits lost");

    idle3_a: assert property (
        @(posedge clk) disable iff (reset)
        net3Held_s |=> $stable(readData[7:4]))
        else $error("net3 bits changed without a write");

    idle2_a: assert property (
        @(posedge clk) disable iff (reset)
        net2Held_s |=> $stable(readData[3:0]))
        else $error("net2 bits changed without a write");

    exit3_a: assert property (
        @(posedge clk) disable iff (reset)
        down3Exit_s |-> (net3TermAConnect == readData[6] && net3WiperConnect == readData[5]
        && net3TermBConnect == readData[4] && !net3WiperToB))
        else $error("net3 did not resume its bits");

    exit2_a: assert property (
        @(posedge clk) disable iff (reset)
        down2Exit_s |-> (net2TermAConnect == readData[2] && net2WiperConnect == readData[1]
        && net2TermBConnect == readData[0] && !net2WiperToB))
        else $error("net2 did not resume its bits");
endmodule // pot23_terminal_connect_ctrl

//--- common/pot23_defs.svh
`ifndef POT23_DEFS_SVH
`define POT23_DEFS_SVH
`define POT23_REG_W 9
`define POT23_RESET_VAL 9'h1ff
`define POT23_RSVD_BIT 8
`define POT23_N3_FORCE_N_BIT 7
`define POT23_N3_A_BIT 6
`define POT23_N3_W_BIT 5
`define POT23_N3_B_BIT 4
`define POT23_N2_FORCE_N_BIT 3
`define POT23_N2_A_BIT 2
`define POT23_N2_W_BIT 1
`define POT23_N2_B_BIT 0
`define POT23_NET_W 4
`endif

//--- common/pot23_pkg.sv
package pot23_pkg;
    typedef logic [3:0] pot23_net_t;
    typedef enum logic {POT23_NORMAL, POT23_SHUTDOWN} pot23_mode_e;
endpackage

//--- dv/test_pot23_terminal_connect_ctrl.sv
`timescale 1ns/1ps
module test_pot23_terminal_connect_ctrl;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic writeStrobe = 1'b0;
    logic net2Lock = 1'b0;
    logic net3Lock = 1'b0;
    logic [8:0] writeData = 9'h000;
    logic [8:0] readData;
    logic [8:0] model = 9'h1ff;
    wire [7:0] outs;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    // {net3Lock, net2Lock, writeData, expected register bits 7:0}
    logic [18:0] rows [9] = '{19'h07777, 19'h1aaaa, 19'h15555, 19'h40050, 19'h3fff0,
        19'h6f0f0, 19'h18888, 19'h0dddd, 19'h1eeee};
    pot23_terminal_connect_ctrl DUT (.clk(clk), .reset(reset), .writeStrobe(writeStrobe), .writeData(writeData),
        .net2Lock(net2Lock), .net3Lock(net3Lock), .readData(readData), .net3TermAConnect(outs[7]),
        .net3WiperConnect(outs[6]), .net3TermBConnect(outs[5]), .net3WiperToB(outs[4]),
        .net2TermAConnect(outs[3]), .net2WiperConnect(outs[2]), .net2TermBConnect(outs[1]), .net2WiperToB(outs[0]));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 200) begin
            errors++;
            summarize();
        end
    end
    // nibble is {force_n, A, W, B}; pins are {A, W, B, wiperToB}
    function automatic logic [3:0] pins(logic [3:0] n);
        return n[3] ? {n[2:0], 1'b0} : 4'b0111;
    endfunction
    task automatic check(string what);
        n_compared++;
        if (readData !== {1'b1, model[7:0]} || outs !== {pins(model[7:4]), pins(model[3:0])}) begin
            errors++;
            $display("wrong value at %0t: %s read %h pins %b", $time, what, readData, outs);
        end
    endtask
    // strobe stays up so consecutive calls write back to back
    task automatic wr(logic [18:0] r);
        {net3Lock, net2Lock, writeData} = r[18:8];
        writeStrobe = 1'b1;
        model[7:0] = r[7:0];
        @(posedge clk);
        #1;
        check("write");
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1 check("in reset");
        reset = 1'b0;
        @(posedge clk);
        #1 check("after reset");
        foreach (rows[i]) wr(rows[i]);
        writeStrobe = 1'b0;
        writeData = 9'h000;
        @(posedge clk);
        #1 check("idle strobe");
        $display("test rows done");
        net3Lock = 1'b1;
        reset = 1'b1;
        model = 9'h1ff;
        #1 check("mid reset");
        @(posedge clk);
        #1 reset = 1'b0;
        wr(19'h400f0);
        $display("test reset done");
        summarize();
    end
endmodule // test_pot23_terminal_connect_ctrl
